// ==== hdl/ppt_map.svh ====
`ifndef PPT_MAP_SVH
`define PPT_MAP_SVH

// Register byte addresses on the APB side.
`define OFS_DATA     8'h00
`define OFS_STATUS   8'h04
`define OFS_CTRL     8'h08
`define OFS_EPP_ADDR 8'h0C
`define OFS_EPP_DATA 8'h10
`define OFS_COMPAT_MODE_FIFO    8'h14
`define OFS_DFIFO    8'h18
`define OFS_TEST_FIFO_PORT    8'h1C
`define OFS_AFIFO    8'h20
`define OFS_CONFIG_A    8'h24
`define OFS_CONFIG_B    8'h28
`define OFS_ECR      8'h2C

// Port control field positions.
`define CTRL_STROBE  0
`define CTRL_AUTOFD  1
`define CTRL_INIT_N  2
`define CTRL_SELIN   3
`define CTRL_ACKIEN  4
`define CTRL_DIR     5

// Extended control field positions.
`define ECR_MODE_LSB 5
`define ECR_MODE_MSB 7

// Reset and fixed values.
`define CTRL_RESET   6'h00
`define ECR_RESET    6'h00
`define DATA_RESET   8'h00
`define CONFIG_A_VALUE  8'h10
`define MODE_EPP     3'h4

// Cycle watchdog.
`define CLK_PERIOD_NS  40
`define EPP_TIMEOUT_NS 10000
`define EPP_TIMEOUT_CYC (`EPP_TIMEOUT_NS / `CLK_PERIOD_NS)

// Run-length expansion: a count of 63 yields 64 copies.
`define RLE_MAX_REPEAT 6'h3F

`endif

// ==== hdl/ppt_pkg.sv ====
package ppt_pkg;

   typedef struct packed {
      logic       wait_n;
      logic       peripheral_interrupt_line;
      logic       busy;
      logic       ack_n;
      logic       perr;
      logic       select;
      logic       fault_n;
      logic [7:0] lines;
   } pin_in_t;

   typedef struct packed {
      logic       data_strobe_n;
      logic       addr_strobe_n;
      logic       write_n;
      logic       reset_n;
      logic       strobe_n;
      logic       autofd_n;
      logic       select_in_n;
      logic [7:0] lines_out;
      logic       lines_oe_n;
   } pin_out_t;

   typedef enum logic [2:0] {
      EPP_IDLE = 3'b001,
      EPP_STRB = 3'b010,
      EPP_DONE = 3'b100
   } epp_state_t;

endpackage

// ==== hdl/shared_byte_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module shared_byte_fifo
   import ppt_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] din,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head,
   output logic                  full,
   output logic                  empty
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             do_push;
   logic             do_pop;

   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign full    = (count_ff == (AW+1)'(DEPTH));
   assign empty   = (count_ff == '0);
   assign head    = mem[rd_ptr_ff];

   always_ff @(posedge pclk) begin
      if (ce && do_push) begin
         mem[wr_ptr_ff] <= din;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else if (ce) begin
         if (do_push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (do_pop && !do_push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

endmodule // shared_byte_fifo

`default_nettype wire

// ==== hdl/epp_ecp_port.sv ====
// Functional notes
// R1: Stretch the APB read with wait states while peripheral_wait is low.
// R2: Software sets port_direction_bit to 1 before a read, releasing lines.
// R3: Host read of an EPP port asserts the data or address strobe.
// R4: Keep waiting until peripheral_wait rises or the watchdog expires.
// R5: Peripheral drives valid bytes, then raises peripheral_wait.
// R6: On wait release, complete the read and drop the strobe used.
// R7: Peripheral releases its byte lines after the strobe drops.
// R8: Write indicator, direction and byte lines change only between cycles.
// R9: write_indicator is low for a write transfer, high otherwise; the code also holds it low while idle with the direction bit clear.
// R10: Peripheral interrupt is active high, passed through uninverted.
// R11: Peripheral raises wait to acknowledge, lowers it when ready again.
// R12: Data strobe marks data transfers, address strobe marks address ones.
// R13: An active-low reset output returns the peripheral to its start mode.
// R14: During a cycle control register may override only write_indicator.
// R15: Software keeps control_direction_bit as required for reads.
// R16: All four FIFO views share one 16-byte buffer.
// R17: Status and control registers stay reachable in every mode.
// R18: Config B reports chip-level interrupt and DMA selections live.
// R19: Every port word is 8 bits wide.
// R20: Optional run_length_code expansion of up to 64 copies per byte.
// R21: A 10 us watchdog aborts a cycle and sets status bit 0.
// R22: Byte lines are captured into read data when the wait line rises.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`include "ppt_map.svh"
`timescale 1ns/1ps
`default_nettype none

module epp_ecp_port
   import ppt_pkg::*;
#(
   parameter int  WORD_W      = 8,
   parameter int  FIFO_DEPTH  = 16,
   parameter bit  RLE_SUPPORT = 1'b1
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire pin_in_t     pins_in,
   input  wire logic [2:0]  chip_irq_sel,
   input  wire logic [2:0]  chip_dma_sel,
   output pin_out_t         pins_out,
   output logic             host_peripheral_interrupt_line
);
   localparam logic [7:0] TIMEOUT_CYC = 8'(`EPP_TIMEOUT_CYC);

   pin_in_t             sync1_ff;
   pin_in_t             sync2_ff;
   epp_state_t          state_ff;
   logic [7:0]          timer_ff;
   logic [WORD_W-1:0]   data_ff;
   logic [5:0]          ctrl_ff;
   logic [5:0]          ecr_ff;
   logic                timeout_ff;
   logic [5:0]          rep_ff;
   logic [31:0]         prdata_ff;
   logic                pready_ff;
   logic                pslverr_ff;
   pin_out_t            pins_ff;
   logic                host_peripheral_interrupt_line_ff;

   logic                setup;
   logic                xfer_done;
   logic                mode_epp;
   logic                epp_read_req;
   logic                wait_high;
   logic                abort;
   logic                finish;
   logic [WORD_W-1:0]   rd_val;
   logic                rd_err;
   logic [WORD_W-1:0]   fifo_head;
   logic                fifo_full;
   logic                fifo_empty;
   logic                fifo_push;
   logic [WORD_W-1:0]   fifo_din;
   logic                fifo_pop;
   logic                rle_load;
   logic                rep_step;

   function automatic logic is_epp_port(input logic [7:0] a);
      return (a == `OFS_EPP_ADDR) || (a == `OFS_EPP_DATA);
   endfunction

   function automatic logic is_fifo_read(input logic [7:0] a);
      return (a == `OFS_COMPAT_MODE_FIFO) || (a == `OFS_DFIFO) ||
             (a == `OFS_TEST_FIFO_PORT);
   endfunction

   // Every pin input passes two flip-flops before any logic looks at it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else if (ce) begin
         sync1_ff <= pins_in;
         sync2_ff <= sync1_ff;
      end
   end

   assign setup        = psel && !penable;
   assign xfer_done    = psel && penable && pready_ff;
   assign mode_epp     = (ecr_ff[`ECR_MODE_MSB-2:`ECR_MODE_LSB-2]
                          == `MODE_EPP);
   assign epp_read_req = setup && !pwrite && is_epp_port(paddr) &&
                         mode_epp && (state_ff == EPP_IDLE);
   assign wait_high    = sync2_ff.wait_n;
   assign abort        = (state_ff == EPP_STRB) && !wait_high &&
                         (timer_ff == TIMEOUT_CYC - 8'd1); // R21
   assign finish       = (state_ff == EPP_STRB) && (wait_high || abort);

   // Read value and error answer for every access other than an EPP read.
   always_comb begin
      rd_val = '0;
      rd_err = 1'b0;
      unique case (paddr)
         `OFS_DATA: begin
            rd_val = ctrl_ff[`CTRL_DIR] ? sync2_ff.lines : data_ff;
         end
         `OFS_STATUS: begin
            rd_val = {!sync2_ff.busy, sync2_ff.ack_n, sync2_ff.perr,
                      sync2_ff.select, sync2_ff.fault_n, 2'b00,
                      timeout_ff}; // R17
         end
         `OFS_CTRL: begin
            rd_val = {2'b00, ctrl_ff}; // R17
         end
         `OFS_COMPAT_MODE_FIFO, `OFS_DFIFO, `OFS_TEST_FIFO_PORT: begin
            rd_val = fifo_head;
            rd_err = pwrite && fifo_full;
         end
         `OFS_AFIFO: begin
            rd_err = pwrite && fifo_full && !(RLE_SUPPORT && !pwdata[7]);
         end
         `OFS_CONFIG_A: begin
            rd_val = `CONFIG_A_VALUE;
         end
         `OFS_CONFIG_B: begin
            rd_val = {RLE_SUPPORT, sync2_ff.peripheral_interrupt_line, chip_irq_sel,
                      chip_dma_sel}; // R18
         end
         `OFS_ECR: begin
            rd_val = {ecr_ff, fifo_full, fifo_empty};
         end
         `OFS_EPP_ADDR, `OFS_EPP_DATA: begin
            rd_err = 1'b1;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // APB answer: zero wait states for plain registers, stretched for EPP-mode reads of the EPP ports.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= '0;
         pslverr_ff <= 1'b0;
      end else if (ce) begin
         if (xfer_done) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
         end else if (setup && !epp_read_req) begin
            pready_ff  <= 1'b1;
            prdata_ff  <= {24'h0000_00, rd_val}; // R19
            pslverr_ff <= rd_err;
         end else if (finish) begin
            pready_ff  <= 1'b1; // R1 R6
            prdata_ff  <= abort ? 32'h0000_0000
                                : {24'h0000_00, sync2_ff.lines}; // R22
            pslverr_ff <= abort;
         end
      end
   end

   // Read cycle sequencer and watchdog.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= EPP_IDLE;
         timer_ff <= '0;
      end else if (ce) begin
         unique case (state_ff)
            EPP_IDLE: begin
               timer_ff <= '0;
               if (epp_read_req) begin
                  state_ff <= EPP_STRB;
               end
            end
            EPP_STRB: begin
               if (finish) begin
                  state_ff <= EPP_DONE; // R4
               end else begin
                  timer_ff <= timer_ff + 8'd1; // R1 R4
               end
            end
            EPP_DONE: begin
               if (xfer_done) begin
                  state_ff <= EPP_IDLE;
               end
            end
         endcase
      end
   end

   // Strobes, write indicator, byte-line drive and the plain control lines
   // share one process so that the output struct has a single driver.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_ff.data_strobe_n <= 1'b1;
         pins_ff.addr_strobe_n <= 1'b1;
         pins_ff.write_n       <= 1'b1;
         pins_ff.lines_out     <= `DATA_RESET;
         pins_ff.lines_oe_n    <= 1'b1;
         pins_ff.reset_n       <= 1'b0;
         pins_ff.strobe_n      <= 1'b1;
         pins_ff.autofd_n      <= 1'b1;
         pins_ff.select_in_n   <= 1'b1;
      end else if (ce) begin
         pins_ff.reset_n     <= ctrl_ff[`CTRL_INIT_N]; // R13
         pins_ff.strobe_n    <= !ctrl_ff[`CTRL_STROBE];
         pins_ff.autofd_n    <= !ctrl_ff[`CTRL_AUTOFD];
         pins_ff.select_in_n <= !ctrl_ff[`CTRL_SELIN];
         if (epp_read_req) begin
            pins_ff.data_strobe_n <= (paddr != `OFS_EPP_DATA); // R3 R12
            pins_ff.addr_strobe_n <= (paddr != `OFS_EPP_ADDR); // R3 R12
            pins_ff.lines_oe_n    <= 1'b1; // R3
            pins_ff.write_n       <= !ctrl_ff[`CTRL_STROBE]; // R14
         end else if (finish) begin
            pins_ff.data_strobe_n <= 1'b1; // R6
            pins_ff.addr_strobe_n <= 1'b1; // R6
         end else if (state_ff == EPP_IDLE) begin
            pins_ff.write_n    <= ctrl_ff[`CTRL_DIR] &&
                                  !ctrl_ff[`CTRL_STROBE]; // R8 R9 R14
            pins_ff.lines_oe_n <= ctrl_ff[`CTRL_DIR]; // R8
            pins_ff.lines_out  <= data_ff; // R8
         end else if (state_ff != EPP_IDLE) begin
            pins_ff.write_n <= !ctrl_ff[`CTRL_STROBE]; // R14
         end
      end
   end

   // Host interrupt follows the synchronised peripheral line when enabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_peripheral_interrupt_line_ff <= 1'b0;
      end else if (ce) begin
         host_peripheral_interrupt_line_ff <= sync2_ff.peripheral_interrupt_line && ctrl_ff[`CTRL_ACKIEN]; // R10
      end
   end

   // Software-visible registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_ff <= `DATA_RESET;
         ctrl_ff <= `CTRL_RESET;
         ecr_ff  <= `ECR_RESET;
      end else if (ce && xfer_done && pwrite) begin
         unique case (paddr)
            `OFS_DATA: data_ff <= pwdata[WORD_W-1:0];
            `OFS_CTRL: ctrl_ff <= pwdata[5:0]; // R17
            `OFS_ECR:  ecr_ff  <= pwdata[7:2];
            default: begin
            end
         endcase
      end
   end

   // Watchdog flag: set on abort, cleared by a status read; set wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_ff <= 1'b0;
      end else if (ce) begin
         if (abort) begin
            timeout_ff <= 1'b1; // R21
         end else if (xfer_done && !pwrite && paddr == `OFS_STATUS) begin
            timeout_ff <= 1'b0;
         end
      end
   end

   // Run-length expansion: the head byte is returned rep_ff+1 times.
   assign rle_load  = RLE_SUPPORT && xfer_done && pwrite &&
                      (paddr == `OFS_AFIFO) && !pwdata[7]; // R20
   assign rep_step  = xfer_done && !pwrite && (paddr == `OFS_DFIFO) &&
                      !fifo_empty && (rep_ff != 6'h00);
   assign fifo_push = xfer_done && pwrite && !rle_load &&
                      ((paddr == `OFS_AFIFO) || is_fifo_read(paddr));
   assign fifo_din  = pwdata[WORD_W-1:0];
   assign fifo_pop  = xfer_done && !pwrite && is_fifo_read(paddr) &&
                      !rep_step;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rep_ff <= '0;
      end else if (ce) begin
         if (rle_load) begin
            rep_ff <= (pwdata[6:0] > 7'(`RLE_MAX_REPEAT)) ?
                      `RLE_MAX_REPEAT : pwdata[5:0]; // R20
         end else if (rep_step) begin
            rep_ff <= rep_ff - 6'h01;
         end
      end
   end

   shared_byte_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .push    (fifo_push), // R16
      .din     (fifo_din),
      .pop     (fifo_pop),
      .head    (fifo_head),
      .full    (fifo_full),
      .empty   (fifo_empty)
   );

   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign pins_out  = pins_ff;
   assign host_peripheral_interrupt_line = host_peripheral_interrupt_line_ff;

endmodule // epp_ecp_port

`default_nettype wire

// ==== bench/epp_port_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ppt_map.svh"
module epp_port_checker
   import ppt_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire pin_in_t    pins_in,
   input wire pin_out_t   pins_out,
   input wire logic       host_peripheral_interrupt_line
);
   logic       stb_low;
   logic [8:0] low_cnt_ff;
   logic [8:0] nxt_low_cnt;
   assign stb_low = !pins_out.data_strobe_n || !pins_out.addr_strobe_n;
   assign nxt_low_cnt = stb_low ? low_cnt_ff + 9'h001 : 9'h000;
   // Counts the cycles a strobe has been low, to bound the watchdog.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_ff <= 9'h000;
      end else begin
         low_cnt_ff <= nxt_low_cnt;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   sequence s_wait_lo;
      !pins_in.wait_n [*4];
   endsequence
   a_dstb_read: assert property (s_rd(`OFS_EPP_DATA) |=>
      pins_out.addr_strobe_n && (!pins_out.data_strobe_n || pslverr))
      else $error("data port read without data strobe");
   a_astb_read: assert property (s_rd(`OFS_EPP_ADDR) |=>
      pins_out.data_strobe_n && (!pins_out.addr_strobe_n || pslverr))
      else $error("address port read without address strobe");
   a_wait_stretch: assert property (s_wait_lo ##0 $past(stb_low)
      |-> !pready || pslverr) else $error("read ended while wait low");
   a_strobe_done: assert property ($rose(stb_low) == 1'b0
      && $fell(stb_low) |-> pready) else $error("strobe dropped early");
   a_lines_free: assert property (stb_low |-> pins_out.lines_oe_n)
      else $error("byte lines driven during read");
   a_write_hold: assert property (stb_low && $past(stb_low)
      |-> $stable(pins_out.write_n)) else $error("write_n moved in cycle");
   a_wdog_max: assert property (low_cnt_ff <= 9'h0FD)
      else $error("strobe held past watchdog");
   a_wdog_window: assert property (pready && pslverr && $past(stb_low)
      |-> low_cnt_ff >= 9'h0F8 && low_cnt_ff <= 9'h0FD)
      else $error("watchdog abort at wrong time");
   a_peripheral_interrupt_line_pass: assert property ($rose(host_peripheral_interrupt_line)
      |-> $past(pins_in.peripheral_interrupt_line, 2) && $past(pins_in.peripheral_interrupt_line, 3))
      else $error("host interrupt without peripheral interrupt");
   a_pready_once: assert property (pready |=> !pready)
      else $error("pready held two cycles");
endmodule // epp_port_checker
bind epp_ecp_port epp_port_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
   .pins_out(pins_out), .host_peripheral_interrupt_line(host_peripheral_interrupt_line));
`default_nettype wire

// ==== bench/epp_periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module epp_periph_model
   import ppt_pkg::*;
(
   input  wire logic       pclk,
   input  wire pin_out_t   pins_out,
   input  wire logic [7:0] data_byte,
   input  wire logic [7:0] addr_byte,
   input  wire logic [7:0] delay,
   input  wire logic       hang,
   output logic            wait_n,
   output logic [7:0]      lines
);
   logic [7:0] cnt;
   logic       stb_on;
   assign stb_on = !pins_out.data_strobe_n || !pins_out.addr_strobe_n;
   initial begin
      wait_n = 1'b0;
      lines  = 8'h5A;
      cnt    = 8'h00;
   end
   // A released bus toggles every cycle, alternating between the last byte and its complement.
   always @(posedge pclk) begin
      if (!stb_on) begin
         wait_n <= 1'b0;
         lines  <= ~lines;
         cnt    <= 8'h00;
      end else if (cnt < delay) begin
         lines <= ~lines;
         cnt   <= cnt + 8'h01;
      end else begin
         lines <= pins_out.addr_strobe_n ? data_byte : addr_byte;
         if (cnt > delay && !hang) begin
            wait_n <= 1'b1;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end
endmodule // epp_periph_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ppt_map.svh"
`define CHK(nm, e, g) begin \
   checks++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("unexpected %s: expected %h seen %h", nm, e, g); \
   end \
end
module tb_top;
   import ppt_pkg::*;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic        host_peripheral_interrupt_line, peripheral_interrupt_line_r, m_wait, hang, err;
   logic [7:0]  paddr, line_lvl, m_lines, d_byte, a_byte, dly, b;
   logic [31:0] pwdata, prdata, rd, x;
   logic [4:0]  sts_r;
   logic [2:0]  irq_sel, dma_sel;
   pin_in_t     pins_in;
   pin_out_t    pins_out;
   int          fail_count, checks;
   logic [7:0]  q[$];
   assign line_lvl = pins_out.lines_oe_n ? m_lines : pins_out.lines_out;
   assign pins_in = {m_wait, peripheral_interrupt_line_r, sts_r, line_lvl};
   epp_ecp_port u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins_in(pins_in), .chip_irq_sel(irq_sel),
      .chip_dma_sel(dma_sel), .pins_out(pins_out),
      .host_peripheral_interrupt_line(host_peripheral_interrupt_line));
   epp_periph_model u_periph (.pclk(pclk), .pins_out(pins_out),
      .data_byte(d_byte), .addr_byte(a_byte), .delay(dly), .hang(hang),
      .wait_n(m_wait), .lines(m_lines));
   initial pclk = 1'b0;
   always #20 pclk = ~pclk;
   task automatic give_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 400);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 400) begin
         fail_count++;
         give_verdict();
      end
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(nm, e, rd)
      `CHK("pslverr", ee, err)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic ee);
      apb(1'b1, a, d);
      `CHK("write pslverr", ee, err)
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      fail_count = 0;
      checks = 0;
      void'($urandom(32'h4e98_8085));
      x = $urandom;
      {presetn, ce, psel, penable, pwrite, peripheral_interrupt_line_r, hang} = 7'b010_0000;
      {paddr, pwdata, d_byte, a_byte, dly} = '0;
      {sts_r, irq_sel, dma_sel} = {x[4:0], 3'h5, 3'h2};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("reset line", 1'b0, pins_out.reset_n)
      rdc("ctrl", `OFS_CTRL, 32'h0000_0000, 1'b0);
      rdc("config_a", `OFS_CONFIG_A, 32'h0000_0010, 1'b0);
      rdc("ecr", `OFS_ECR, 32'h0000_0001, 1'b0);
      rdc("unmapped", 8'h30, 32'h0000_0000, 1'b1);
      for (int i = 0; i < 3; i++) begin
         x = $urandom;
         irq_sel <= x[2:0];
         dma_sel <= x[5:3];
         rdc("config_b", `OFS_CONFIG_B, {24'h0, 2'b10, x[2:0], x[5:3]}, 0);
      end
      wr(`OFS_CTRL, 32'h0000_0004, 1'b0);
      `CHK("reset line", 1'b1, pins_out.reset_n)
      `CHK("write_n", 1'b0, pins_out.write_n)
      wr(`OFS_DATA, 32'h0000_00A5, 1'b0);
      `CHK("lines_out", 8'hA5, pins_out.lines_out)
      `CHK("lines_oe_n", 1'b0, pins_out.lines_oe_n)
      rdc("data", `OFS_DATA, 32'h0000_00A5, 1'b0);
      wr(`OFS_CTRL, 32'h0000_0024, 1'b0);
      `CHK("write_n", 1'b1, pins_out.write_n)
      rdc("epp off", `OFS_EPP_DATA, 32'h0000_0000, 1'b1);
      wr(`OFS_ECR, 32'h0000_0080, 1'b0);
      rdc("status", `OFS_STATUS, {~sts_r[4], sts_r[3:0], 3'b000}, 0);
      for (int i = 0; i < 8; i++) begin
         x = $urandom;
         d_byte <= x[7:0];
         a_byte <= x[15:8];
         dly <= (i < 2) ? 8'h00 : {3'b000, x[20:16]};
         if (i[0]) rdc("epp addr", `OFS_EPP_ADDR, x[15:8], 0);
         else rdc("epp data", `OFS_EPP_DATA, x[7:0], 0);
      end
      hang <= 1'b1;
      dly <= 8'h00;
      rdc("epp abort", `OFS_EPP_DATA, 32'h0000_0000, 1'b1);
      hang <= 1'b0;
      rdc("timeout", `OFS_STATUS, {~sts_r[4], sts_r[3:0], 3'b001}, 0);
      rdc("cleared", `OFS_STATUS, {~sts_r[4], sts_r[3:0], 3'b000}, 0);
      for (int i = 0; i < 17; i++) begin
         x = $urandom;
         wr((i % 3 == 0) ? `OFS_COMPAT_MODE_FIFO : (i % 3 == 1) ? `OFS_DFIFO
            : `OFS_TEST_FIFO_PORT, {24'h0, x[7:0]}, i == 16);
         if (i < 16) q.push_back(x[7:0]);
      end
      rdc("ecr full", `OFS_ECR, 32'h0000_0082, 1'b0);
      for (int i = 0; i < 16; i++) begin
         b = q.pop_front();
         rdc("fifo", i[0] ? `OFS_TEST_FIFO_PORT : `OFS_COMPAT_MODE_FIFO, {24'h0, b}, 0);
      end
      rdc("ecr empty", `OFS_ECR, 32'h0000_0081, 1'b0);
      x = $urandom;
      wr(`OFS_AFIFO, 32'h0000_007F, 1'b0);
      wr(`OFS_DFIFO, {24'h0, x[7:0]}, 1'b0);
      rdc("afifo", `OFS_AFIFO, 32'h0000_0000, 1'b0);
      // A count above 63 is clamped, so exactly 64 copies come out.
      for (int i = 0; i < 64; i++) rdc("rle", `OFS_DFIFO, x[7:0], 0);
      rdc("rle end", `OFS_ECR, 32'h0000_0081, 1'b0);
      wr(`OFS_CTRL, 32'h0000_0014, 1'b0);
      peripheral_interrupt_line_r <= 1'b1;
      repeat (6) @(posedge pclk);
      `CHK("host_peripheral_interrupt_line", 1'b1, host_peripheral_interrupt_line)
      rdc("config_b", `OFS_CONFIG_B, {24'h0, 2'b11, irq_sel, dma_sel}, 0);
      peripheral_interrupt_line_r <= 1'b0;
      repeat (6) @(posedge pclk);
      `CHK("host_peripheral_interrupt_line", 1'b0, host_peripheral_interrupt_line)
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
